// ===== include/xfer_pkg.sv
// Purpose: shared constants for the data transfer executor
// Assumes: 8-bit data path, 16-bit wide timer
// Notes: register offsets are byte addresses on the Avalon-MM slave
package xfer_pkg;
    localparam int DATA_W = 8;
    localparam int MADDR_W = 8;
    localparam int IOADDR_W = 6;
    localparam logic [7:0] BIT_ADDR_MAX = 8'h3F;
    // register byte offsets
    localparam logic [5:0] OFF_CMD = 6'h00;
    localparam logic [5:0] OFF_OPND = 6'h04;
    localparam logic [5:0] OFF_STATUS = 6'h08;
    localparam logic [5:0] OFF_WORK = 6'h0C;
    localparam logic [5:0] OFF_TIMER = 6'h10;
    localparam logic [5:0] OFF_MEMWIN = 6'h14;
    localparam logic [5:0] OFF_IOWIN = 6'h18;
    localparam logic [5:0] OFF_ALU = 6'h1C;
    // flag positions in the status word
    localparam int FLAG_Z = 0;
    localparam int FLAG_C = 1;
    localparam int FLAG_AC = 2;
    localparam int FLAG_OV = 3;
    localparam int STAT_BUSY = 4;
    localparam int STAT_BADBIT = 5;
    localparam logic [7:0] WORK_RESET = 8'h00;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    localparam logic [15:0] TIMER_RESET = 16'h0000;
    typedef enum logic [3:0] {
        OP_NONE, OP_LD_IMM, OP_ST_MEM, OP_LD_MEM, OP_LD_IO, OP_ST_IO,
        OP_TMR_RD, OP_TMR_WR, OP_ADD, OP_SUB, OP_BIT_SET, OP_BIT_CLR
    } op_e;
endpackage

// ===== src/xfer_core.sv
// Purpose: executes data transfer moves, flag updates and timer word moves
// Assumes: Avalon-MM slave with waitrequest, single 200 MHz clock
// Notes: data memory and IO space are local arrays
`timescale 1ns/1ps
`default_nettype none
module xfer_core
    import xfer_pkg::*;
#(
    parameter int MEM_DEPTH = 256,
    parameter int IO_DEPTH = 64
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic timer_tick,
    output logic [15:0] wide_timer
);
    import xfer_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DONE} state_e;

    logic [7:0] mem_r [MEM_DEPTH];
    logic [7:0] io_r [IO_DEPTH];
    state_e state_r;
    logic [3:0] op_r;
    logic [7:0] addr_r;
    logic [7:0] imm_r;
    logic [2:0] bitsel_r;
    logic [7:0] work_register_r;
    logic zero_flag_r, carry_flag_r, nibble_carry_flag_r, signed_range_flag_r;
    logic bad_bit_r;
    logic [15:0] timer_r;
    logic ack_r;
    logic [31:0] rdata_r;

    // bus decode
    wire req = avs_read | avs_write;
    wire wr_cmd = avs_write && avs_address == OFF_CMD && avs_byteenable[0];
    wire wr_opnd = avs_write && avs_address == OFF_OPND;
    wire wr_timer = avs_write && avs_address == OFF_TIMER;
    wire wr_memwin = avs_write && avs_address == OFF_MEMWIN && avs_byteenable[0];
    wire wr_iowin = avs_write && avs_address == OFF_IOWIN && avs_byteenable[0];
    wire cmd_go = wr_cmd && ack_r && state_r == ST_IDLE;
    wire busy = state_r != ST_IDLE;
    // commands wait while an instruction executes
    assign avs_waitrequest = req && (!ack_r || (wr_cmd && busy && !ack_r));
    assign avs_readdata = rdata_r;
    assign wide_timer = timer_r;

    function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b, input logic sub);
        add9 = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
    endfunction

    // alu on work register and memory operand
    wire [7:0] mem_opnd = mem_r[addr_r];
    wire is_sub = op_r == OP_SUB;
    wire [8:0] alu_sum = add9(work_register_r, mem_opnd, is_sub);
    wire [4:0] nib_sum = is_sub ? ({1'b0, work_register_r[3:0]} - {1'b0, mem_opnd[3:0]})
                                : ({1'b0, work_register_r[3:0]} + {1'b0, mem_opnd[3:0]});
    wire [7:0] alu_res = alu_sum[7:0];
    wire alu_ov = is_sub ? ((work_register_r[7] != mem_opnd[7]) && (alu_res[7] != work_register_r[7]))
                         : ((work_register_r[7] == mem_opnd[7]) && (alu_res[7] != work_register_r[7]));
    wire bit_ok = addr_r <= BIT_ADDR_MAX;
    wire [7:0] io_val = io_r[addr_r[IOADDR_W-1:0]];
    wire [7:0] addr_hi = addr_r + 8'h01;
    wire [7:0] bit_mask = 8'h01 << bitsel_r;
    wire execute = state_r == ST_EXEC;
    wire [3:0] status_bits = {signed_range_flag_r, nibble_carry_flag_r, carry_flag_r, zero_flag_r};

    // read data mux
    logic [31:0] rd_nxt;
    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (avs_address)
            OFF_CMD: rd_nxt = {28'h0000000, op_r};
            OFF_OPND: rd_nxt = {13'h0000, bitsel_r, imm_r, addr_r};
            OFF_STATUS: rd_nxt = {26'h0000000, bad_bit_r, busy, status_bits};
            OFF_WORK: rd_nxt = {24'h000000, work_register_r};
            OFF_TIMER: rd_nxt = {16'h0000, timer_r};
            OFF_MEMWIN: rd_nxt = {24'h000000, mem_r[addr_r]};
            OFF_IOWIN: rd_nxt = {24'h000000, io_val};
            OFF_ALU: rd_nxt = {23'h000000, alu_sum};
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    // one-cycle ack per bus access
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r <= req && !ack_r && !(wr_cmd && busy);
            rdata_r <= rd_nxt;
        end
    end

    // sequencer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            op_r <= 4'h0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (cmd_go) begin
                        op_r <= avs_writedata[3:0];
                        state_r <= ST_EXEC;
                    end
                end
                ST_EXEC: state_r <= ST_DONE;
                ST_DONE: state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // operand register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_r <= 8'h00;
            imm_r <= 8'h00;
            bitsel_r <= 3'h0;
        end else if (wr_opnd && ack_r) begin
            addr_r <= avs_writedata[7:0];
            imm_r <= avs_writedata[15:8];
            bitsel_r <= avs_writedata[18:16];
        end
    end

    // work register and flags
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            work_register_r <= WORK_RESET;
            {signed_range_flag_r, nibble_carry_flag_r, carry_flag_r, zero_flag_r} <= FLAGS_RESET;
            bad_bit_r <= 1'b0;
        end else if (execute) begin
            case (op_r)
                OP_LD_IMM: work_register_r <= imm_r;
                OP_LD_MEM: begin
                    work_register_r <= mem_opnd;
                    zero_flag_r <= mem_opnd == 8'h00;
                end
                OP_LD_IO: begin
                    work_register_r <= io_val;
                    zero_flag_r <= io_val == 8'h00;
                end
                OP_ADD, OP_SUB: begin
                    work_register_r <= alu_res;
                    zero_flag_r <= alu_res == 8'h00;
                    carry_flag_r <= alu_sum[8];
                    nibble_carry_flag_r <= nib_sum[4];
                    signed_range_flag_r <= alu_ov;
                end
                OP_BIT_SET, OP_BIT_CLR: bad_bit_r <= !bit_ok;
                default: ;
            endcase
        end
    end

    // memory and io arrays
    always_ff @(posedge clk) begin
        if (execute) begin
            case (op_r)
                OP_ST_MEM: mem_r[addr_r] <= work_register_r;
                OP_ST_IO: io_r[addr_r[IOADDR_W-1:0]] <= work_register_r;
                OP_TMR_RD: begin
                    mem_r[addr_r] <= timer_r[7:0];
                    mem_r[addr_hi] <= timer_r[15:8];
                end
                OP_BIT_SET: if (bit_ok) mem_r[addr_r] <= mem_opnd | bit_mask;
                OP_BIT_CLR: if (bit_ok) mem_r[addr_r] <= mem_opnd & ~bit_mask;
                default: ;
            endcase
        end else if (wr_memwin && ack_r) begin
            mem_r[addr_r] <= avs_writedata[7:0];
        end else if (wr_iowin && ack_r) begin
            io_r[addr_r[IOADDR_W-1:0]] <= avs_writedata[7:0];
        end
    end

    // wide timer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_r <= TIMER_RESET;
        end else if (execute && op_r == OP_TMR_WR) begin
            timer_r <= {mem_r[addr_hi], mem_r[addr_r]};
        end else if (wr_timer && ack_r) begin
            timer_r <= avs_writedata[15:0];
        end else if (timer_tick) begin
            timer_r <= timer_r + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ===== sim/xfer_core_asserts.sv
// Purpose: port checks for xfer_core
// Assumes: one wait state, one clock
// Notes: bound from tb_top
`timescale 1ns/1ps
`default_nettype none
module xfer_core_asserts
    import xfer_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic timer_tick,
    input wire logic [15:0] wide_timer
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire rd_ok = avs_read && !avs_waitrequest;
    wait_ends_a: assert property ((avs_read || avs_write) |-> ##[0:8] !avs_waitrequest) else $error("wait stuck");
    idle_nowait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest) else $error("idle wait");
    tmr_hold_a: assert property (!timer_tick && !avs_write && !$past(avs_write) && !$past(avs_write, 2)
        && !$past(avs_write, 3) |=> $stable(wide_timer)) else $error("timer moved");
    tmr_tick_a: assert property (timer_tick && !avs_write && !$past(avs_write) && !$past(avs_write, 2)
        && !$past(avs_write, 3) |=> wide_timer == $past(wide_timer) + 16'h0001) else $error("tick lost");
    unmapped_zero_a: assert property (rd_ok && avs_address > 6'h1C |-> avs_readdata == '0) else $error("unmapped");
    status_width_a: assert property (rd_ok && avs_address == OFF_STATUS |-> avs_readdata[31:6] == '0) else $error("st");
    work_width_a: assert property (rd_ok && avs_address == OFF_WORK |-> avs_readdata[31:8] == '0) else $error("wk");
    tmr_width_a: assert property (rd_ok && avs_address == OFF_TIMER |-> avs_readdata[31:16] == '0) else $error("tm");
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// Purpose: self-checking bench for xfer_core
// Assumes: Avalon-MM master, model with arrays
// Notes: xorshift seed 46
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import xfer_pkg::*;
    logic clk, reset_n, avs_read, avs_write, avs_waitrequest, timer_tick;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q, seed;
    logic [3:0] avs_byteenable, fl;
    logic [15:0] wide_timer, t;
    logic [8:0] r;
    logic [7:0] mem [256], wk, x, v;
    int fails, cmp_count;
    xfer_core u_dut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .timer_tick(timer_tick),
        .wide_timer(wide_timer));
    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("Error %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) fails++;
        q = avs_readdata;
        avs_write <= 0;
        avs_read <= 0;
        @(posedge clk);
    endtask
    task automatic exec(input op_e op, input logic [31:0] o);
        int n;
        bus(1, OFF_OPND, o);
        bus(1, OFF_CMD, {28'h0, op});
        n = 0;
        do begin
            bus(0, OFF_STATUS, 0);
            n++;
        end while (q[STAT_BUSY] !== 1'b0 && n < 20);
        if (q[STAT_BUSY] !== 1'b0) fails++;
    endtask
    task automatic mset(input logic [7:0] a, input logic [7:0] d);
        bus(1, OFF_OPND, a);
        bus(1, OFF_MEMWIN, d);
        mem[a] = d;
    endtask
    task automatic mget(input logic [7:0] a);
        bus(1, OFF_OPND, a);
        bus(0, OFF_MEMWIN, 0);
    endtask
    task automatic chkst();
        bus(0, OFF_STATUS, 0);
        chk(q[3:0], fl);
        bus(0, OFF_WORK, 0);
        chk(q[7:0], wk);
    endtask
    task automatic conclude();
        $display("cmp %0d fails %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #200000;
        fails++;
        conclude();
    end
    initial begin
        {avs_address, avs_read, avs_write, avs_writedata, timer_tick, reset_n} = '0;
        avs_byteenable = 4'hF;
        seed = 32'h0000002E;
        wk = WORK_RESET;
        fl = FLAGS_RESET;
        repeat (2) @(posedge clk);
        reset_n <= 1;
        @(posedge clk);
        bus(0, OFF_TIMER, 0);
        chk(q, TIMER_RESET);
        chkst();
        for (int i = 0; i < 8; i++) begin
            x = rnd();
            v = i < 2 ? 8'h80 : rnd();
            if (i < 2) x = 8'h80;
            mset(8'h05, v);
            exec(OP_LD_IMM, {x, 8'h00});
            wk = x;
            chkst();
            exec(i[0] ? OP_SUB : OP_ADD, 8'h05);
            r = i[0] ? {1'b0, x} - v : {1'b0, x} + v;
            fl = {i[0] ? (x[7] != v[7]) && (r[7] != x[7]) : (x[7] == v[7]) && (r[7] != x[7]),
                i[0] ? x[3:0] < v[3:0] : {1'b0, x[3:0]} + v[3:0] > 5'h0F, r[8], r[7:0] == 8'h00};
            wk = r[7:0];
            chkst();
            v = i[1] ? 8'h00 : rnd();
            mset(8'h07, v);
            exec(OP_LD_MEM, 8'h07);
            wk = v;
            fl[FLAG_Z] = v == 8'h00;
            chkst();
            exec(OP_ST_MEM, 8'h20);
            mget(8'h20);
            chk(q[7:0], wk);
            exec(OP_ST_IO, 8'h11);
            bus(0, OFF_IOWIN, 0);
            chk(q[7:0], wk);
            chkst();
            v = i[2] ? 8'h00 : rnd();
            bus(1, OFF_IOWIN, v);
            exec(OP_LD_IO, 8'h11);
            wk = v;
            fl[FLAG_Z] = v == 8'h00;
            chkst();
        end
        $display("move tests done");
        t = rnd();
        bus(1, OFF_TIMER, t);
        exec(OP_TMR_RD, 8'hFF);
        mget(8'hFF);
        chk(q[7:0], t[7:0]);
        mget(8'h00);
        chk(q[7:0], t[15:8]);
        mset(8'h30, ~t[7:0]);
        mset(8'h31, t[7:0]);
        exec(OP_TMR_WR, 8'h30);
        chkst();
        timer_tick <= 1;
        repeat (5) @(posedge clk);
        timer_tick <= 0;
        @(posedge clk);
        bus(0, OFF_TIMER, 0);
        chk(q, {16'h0, t[7:0], ~t[7:0]} + 32'h5);
        chk(wide_timer, {t[7:0], ~t[7:0]} + 16'h5);
        $display("timer tests done");
        mset(8'h40, 8'h00);
        exec(OP_BIT_SET, 32'h00020040);
        chk(q[STAT_BADBIT], 1'b1);
        mget(8'h40);
        chk(q[7:0], 8'h00);
        mset(8'h3F, 8'h00);
        exec(OP_BIT_SET, 32'h0007003F);
        mget(8'h3F);
        chk(q[7:0], 8'h80);
        exec(OP_BIT_CLR, 32'h0007003F);
        mget(8'h3F);
        chk(q[7:0], 8'h00);
        bus(0, 6'h20, 0);
        chk(q, 32'h0);
        $display("bit tests done");
        conclude();
    end
endmodule
bind xfer_core xfer_core_asserts u_chk (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .timer_tick(timer_tick),
    .wide_timer(wide_timer));
`default_nettype wire
